// ===== design/twf_pkg.sv
package twf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // link-side timing
  localparam int LINK_PERIOD_NS = 30;
  localparam int SPIKE_NS = 100;
  // longest spike to swallow, rounded down to whole link cycles
  localparam int FILT_CYC = (SPIKE_NS / LINK_PERIOD_NS < 1) ? 1 : SPIKE_NS / LINK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // byte framing
  localparam logic [3:0] LAST_DATA_POS = 4'h7;
  localparam logic [3:0] ACK_POS = 4'h8;
  localparam logic [3:0] DONE_POS = 4'h9;
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic SDA_PULL_LEVEL = 1'b0;

  typedef enum logic [1:0] {
    LM_STANDBY = 2'b00,
    LM_RX = 2'b01,
    LM_TX = 2'b10,
    LM_HOLD = 2'b11
  } twf_mode_t;

  typedef enum logic [1:0] {
    EV_START = 2'b00,
    EV_STOP = 2'b01,
    EV_BYTE = 2'b10,
    EV_NACK = 2'b11
  } twf_kind_t;

  typedef struct packed {
    twf_kind_t kind;
    logic [7:0] data;
  } twf_evt_t;

  // bit of a byte sent at a position, msb at position zero
  function automatic logic tx_bit(input logic [7:0] b, input logic [3:0] pos);
    logic [2:0] idx;
    idx = 3'h7 - pos[2:0];
    return b[idx];
  endfunction

endpackage

// ===== design/twf_line_filter.sv
module twf_line_filter #(
  parameter int FILT_CYC = twf_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // line
  input wire logic line_in,
  output logic line_out
);

  logic s1;
  logic s2;
  logic s3;
  logic [7:0] cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // three-stage synchroniser
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1 <= twf_pkg::IDLE_LEVEL;
      s2 <= twf_pkg::IDLE_LEVEL;
      s3 <= twf_pkg::IDLE_LEVEL;
    end else begin
      s1 <= line_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // new level must hold for FILT_CYC agreeing samples
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= 8'h00;
      line_out <= twf_pkg::IDLE_LEVEL;
    end else if (s2 == s3 && s3 != line_out) begin
      if (cnt >= 8'(FILT_CYC - 1)) begin
        cnt <= 8'h00;
        line_out <= s3;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end else begin
      cnt <= 8'h00;
    end
  end

  property p_filter_hold;
    @(posedge clk_in) disable iff (!rst_b_in)
    $changed(line_out) |-> $past(cnt) == 8'(FILT_CYC - 1) && $past(s3) == line_out;
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter output moved early");

endmodule

// ===== design/twf_word_cdc.sv
module twf_word_cdc #(
  parameter int W = 8
) (
  // source side
  input wire logic src_clk_in,
  input wire logic src_rst_b_in,
  input wire logic src_valid_in,
  input wire logic [W-1:0] src_data_in,
  output logic src_ready_out,
  // destination side
  input wire logic dst_clk_in,
  input wire logic dst_rst_b_in,
  output logic dst_valid_out,
  output logic [W-1:0] dst_data_out
);

  logic req_t;
  logic [W-1:0] hold;
  logic ack_s1;
  logic ack_s2;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic ack_t;

  ////////////////////////////////////////////////////////////////////////////////
  // source: word held stable until the toggle comes back
  assign src_ready_out = (req_t == ack_s2);

  always_ff @(posedge src_clk_in or negedge src_rst_b_in) begin
    if (!src_rst_b_in) begin
      req_t <= 1'b0;
      hold <= '0;
    end else if (src_valid_in && src_ready_out) begin
      req_t <= ~req_t;
      hold <= src_data_in;
    end
  end

  always_ff @(posedge src_clk_in or negedge src_rst_b_in) begin
    if (!src_rst_b_in) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_t;
      ack_s2 <= ack_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // destination
  always_ff @(posedge dst_clk_in or negedge dst_rst_b_in) begin
    if (!dst_rst_b_in) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req_t;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  always_ff @(posedge dst_clk_in or negedge dst_rst_b_in) begin
    if (!dst_rst_b_in) begin
      dst_valid_out <= 1'b0;
      dst_data_out <= '0;
      ack_t <= 1'b0;
    end else begin
      dst_valid_out <= (req_s2 != req_s3);
      ack_t <= req_s2;
      if (req_s2 != req_s3) begin
        dst_data_out <= hold;
      end
    end
  end

  property p_dst_pulse;
    @(posedge dst_clk_in) disable iff (!dst_rst_b_in)
    dst_valid_out |=> !dst_valid_out;
  endproperty
  a_dst_pulse: assert property (p_dst_pulse) else $error("delivery pulse longer than one cycle");

endmodule

// ===== design/twf_two_wire_target_bus_frontend.sv
module twf_two_wire_target_bus_frontend #(
  parameter int FILT_CYC = twf_pkg::FILT_CYC
) (
  // system clock and power-on reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // link clock sampling the bus
  input wire logic link_clk_in,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // user side, events from the bus
  output logic rx_valid_out,
  output twf_pkg::twf_evt_t rx_evt_out,
  // user side, byte to send
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  // user side, control and status
  input wire logic ack_en_in,
  output logic standby_out
);

  logic lrst_q1;
  logic lrst_b;
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  twf_pkg::twf_mode_t mode;
  twf_pkg::twf_mode_t next_mode;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] pos;
  logic sda_oe;
  logic next_oe;
  logic load_tx;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] tx_buf;
  logic tx_full;
  logic tx_new;
  logic [7:0] tx_word;
  logic ack_s1;
  logic ack_s2;
  logic ack_s3;
  logic ack_en_l;
  logic evt_valid;
  twf_pkg::twf_evt_t evt;
  twf_pkg::twf_evt_t rx_word;
  logic standby_l;
  logic stb_s1;

  ////////////////////////////////////////////////////////////////////////////////
  // link reset: asserted with power-on reset, released on the link clock
  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lrst_q1 <= 1'b0;
      lrst_b <= 1'b0;
    end else begin
      lrst_q1 <= 1'b1;
      lrst_b <= lrst_q1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin conditioning
  twf_line_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
    .clk_in(link_clk_in),
    .rst_b_in(lrst_b),
    .line_in(scl_in),
    .line_out(scl_f)
  );

  twf_line_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
    .clk_in(link_clk_in),
    .rst_b_in(lrst_b),
    .line_in(sda_in),
    .line_out(sda_f)
  );

  always_ff @(posedge link_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      scl_q <= twf_pkg::IDLE_LEVEL;
      sda_q <= twf_pkg::IDLE_LEVEL;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  // sda moving while scl stayed high on both samples is a condition, not data
  assign start_det = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_det = scl_f & scl_q & ~sda_q & sda_f;

  ////////////////////////////////////////////////////////////////////////////////
  // ack enable from the system domain
  always_ff @(posedge link_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      ack_en_l <= 1'b0;
    end else begin
      ack_s1 <= ack_en_in;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      if (ack_s2 == ack_s3) begin
        ack_en_l <= ack_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // framing and drive decisions
  always_comb begin
    pos = (cnt == twf_pkg::DONE_POS) ? 4'h0 : cnt;
    next_mode = mode;
    next_cnt = cnt;
    next_oe = sda_oe;
    load_tx = 1'b0;
    evt_valid = 1'b0;
    evt.kind = twf_pkg::EV_START;
    evt.data = 8'h00;
    if (start_det) begin
      // also covers a repeated start
      next_mode = twf_pkg::LM_RX;
      next_cnt = 4'h0;
      next_oe = 1'b0;
      evt_valid = 1'b1;
    end else if (stop_det) begin
      next_mode = twf_pkg::LM_STANDBY;
      next_cnt = 4'h0;
      next_oe = 1'b0;
      evt_valid = mode != twf_pkg::LM_STANDBY;
      evt.kind = twf_pkg::EV_STOP;
    end else if (mode != twf_pkg::LM_STANDBY) begin
      if (scl_rise) begin
        if (cnt < twf_pkg::ACK_POS) begin
          next_cnt = cnt + 4'h1;
        end
        if (cnt == twf_pkg::LAST_DATA_POS && mode == twf_pkg::LM_RX) begin
          evt_valid = 1'b1;
          evt.kind = twf_pkg::EV_BYTE;
          evt.data = {rx_sh[6:0], sda_f};
        end
        if (cnt == twf_pkg::ACK_POS) begin
          next_cnt = twf_pkg::DONE_POS;
          if (mode == twf_pkg::LM_TX && sda_f) begin
            next_mode = twf_pkg::LM_HOLD;
            evt_valid = 1'b1;
            evt.kind = twf_pkg::EV_NACK;
          end
        end
      end else if (scl_fall) begin
        next_cnt = pos;
        case (mode)
          twf_pkg::LM_RX: begin
            next_oe = (pos == twf_pkg::ACK_POS) & ack_en_l;
            if (cnt == twf_pkg::DONE_POS && tx_full) begin
              next_mode = twf_pkg::LM_TX;
              load_tx = 1'b1;
              next_oe = ~twf_pkg::tx_bit(tx_buf, 4'h0);
            end
          end
          twf_pkg::LM_TX: begin
            if (cnt == twf_pkg::DONE_POS) begin
              if (tx_full) begin
                load_tx = 1'b1;
                next_oe = ~twf_pkg::tx_bit(tx_buf, 4'h0);
              end else begin
                next_mode = twf_pkg::LM_HOLD;
                next_oe = 1'b0;
              end
            end else if (pos < twf_pkg::ACK_POS) begin
              next_oe = ~twf_pkg::tx_bit(tx_sh, pos);
            end else begin
              next_oe = 1'b0;
            end
          end
          default: begin
            next_oe = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      mode <= twf_pkg::LM_STANDBY;
      cnt <= 4'h0;
    end else begin
      mode <= next_mode;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shift registers
  always_ff @(posedge link_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      rx_sh <= 8'h00;
    end else if (mode != twf_pkg::LM_STANDBY && scl_rise && cnt < twf_pkg::ACK_POS) begin
      rx_sh <= {rx_sh[6:0], sda_f};
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      tx_sh <= 8'h00;
    end else if (load_tx) begin
      tx_sh <= tx_buf;
    end
  end

  // a new word arriving wins over the load that empties the buffer
  always_ff @(posedge link_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
    end else if (tx_new) begin
      tx_buf <= tx_word;
      tx_full <= 1'b1;
    end else if (load_tx) begin
      tx_full <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // domain crossings
  twf_word_cdc #(.W(8)) u_tx_cdc (
    .src_clk_in(clk_in),
    .src_rst_b_in(rst_b_in),
    .src_valid_in(tx_valid_in),
    .src_data_in(tx_data_in),
    .src_ready_out(tx_ready_out),
    .dst_clk_in(link_clk_in),
    .dst_rst_b_in(lrst_b),
    .dst_valid_out(tx_new),
    .dst_data_out(tx_word)
  );

  twf_word_cdc #(.W($bits(twf_pkg::twf_evt_t))) u_evt_cdc (
    .src_clk_in(link_clk_in),
    .src_rst_b_in(lrst_b),
    .src_valid_in(evt_valid),
    .src_data_in(evt),
    .src_ready_out(),
    .dst_clk_in(clk_in),
    .dst_rst_b_in(rst_b_in),
    .dst_valid_out(rx_valid_out),
    .dst_data_out(rx_word)
  );

  assign rx_evt_out = rx_word;

  always_ff @(posedge link_clk_in or negedge lrst_b) begin
    if (!lrst_b) begin
      standby_l <= 1'b1;
    end else begin
      standby_l <= (next_mode == twf_pkg::LM_STANDBY);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stb_s1 <= 1'b1;
      standby_out <= 1'b1;
    end else begin
      stb_s1 <= standby_l;
      standby_out <= stb_s1;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = twf_pkg::SDA_PULL_LEVEL;
  assign sda_oe_out = sda_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_por_standby;
    @(posedge link_clk_in) disable iff (!lrst_b)
    $rose(lrst_b) |-> mode == twf_pkg::LM_STANDBY && !sda_oe;
  endproperty
  a_por_standby: assert property (p_por_standby) else $error("not in standby after reset");

  property p_drive_after_fall;
    @(posedge link_clk_in) disable iff (!lrst_b)
    $changed(sda_oe) |-> $past(scl_fall) || $past(start_det) || $past(stop_det);
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall) else $error("sda drive moved off a fall");

  property p_start_wakes;
    @(posedge link_clk_in) disable iff (!lrst_b)
    start_det |=> mode == twf_pkg::LM_RX && cnt == 4'h0 && !standby_l;
  endproperty
  a_start_wakes: assert property (p_start_wakes) else $error("start did not wake the device");

  property p_stop_sleeps;
    @(posedge link_clk_in) disable iff (!lrst_b)
    stop_det |=> mode == twf_pkg::LM_STANDBY ##1 standby_l;
  endproperty
  a_stop_sleeps: assert property (p_stop_sleeps) else $error("stop did not reach standby");

  property p_condition_abandons;
    @(posedge link_clk_in) disable iff (!lrst_b)
    (start_det || stop_det) |=> cnt == 4'h0 && !sda_oe;
  endproperty
  a_condition_abandons: assert property (p_condition_abandons) else $error("byte not abandoned");

  property p_quiet_standby;
    @(posedge link_clk_in) disable iff (!lrst_b)
    mode == twf_pkg::LM_STANDBY |-> !sda_oe;
  endproperty
  a_quiet_standby: assert property (p_quiet_standby) else $error("sda driven in standby");

  property p_ninth_clock;
    @(posedge link_clk_in) disable iff (!lrst_b)
    mode != twf_pkg::LM_STANDBY && scl_rise && cnt == twf_pkg::ACK_POS && !start_det
      |=> cnt == twf_pkg::DONE_POS;
  endproperty
  a_ninth_clock: assert property (p_ninth_clock) else $error("ack clock not counted");

  property p_capture_on_rise;
    @(posedge link_clk_in) disable iff (!lrst_b)
    mode != twf_pkg::LM_STANDBY && scl_rise && cnt < twf_pkg::ACK_POS
      |=> rx_sh[0] == $past(sda_f) && rx_sh[7:1] == $past(rx_sh[6:0]);
  endproperty
  a_capture_on_rise: assert property (p_capture_on_rise) else $error("bit not captured");

  property p_nack_release;
    @(posedge link_clk_in) disable iff (!lrst_b)
    mode == twf_pkg::LM_HOLD |-> !sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("sda held after nack");

  property p_msb_first;
    @(posedge link_clk_in) disable iff (!lrst_b)
    load_tx && !start_det && !stop_det |=> sda_oe == ~tx_sh[7];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not the msb");

endmodule

// ===== dv/twf_bus_master_model.sv
module twf_bus_master_model #(
  parameter int HALF_NS = 500,
  parameter int POWER_UP_COMMAND_WAIT_NS = 100000
) (
  // bus pins
  output logic scl_out,
  output logic sda_pull_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////
  // idle bus: both lines high, nothing pulled
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  task automatic power_up();
    #(POWER_UP_COMMAND_WAIT_NS);
  endtask

  ////////////////////////////////////////////////////////////
  // one scl cycle: data set while scl low, sampled mid-high
  task automatic clk_bit(input logic b, output logic r);
    #(HALF_NS / 4) sda_pull_out = ~b;
    #(3 * HALF_NS / 4) scl_out = 1'b1;
    #(HALF_NS / 2) r = sda_in;
    #(HALF_NS / 2) scl_out = 1'b0;
  endtask

  task automatic start_cond();
    #(HALF_NS / 4) sda_pull_out = 1'b0;
    #(3 * HALF_NS / 4) scl_out = 1'b1;
    #(HALF_NS) sda_pull_out = 1'b1;
    #(HALF_NS) scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    #(HALF_NS / 4) sda_pull_out = 1'b1;
    #(3 * HALF_NS / 4) scl_out = 1'b1;
    #(HALF_NS) sda_pull_out = 1'b0;
    #(HALF_NS);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, ack);
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(nack, r);
  endtask

  // short low spike on sda
  task automatic glitch(input int width);
    sda_pull_out = 1'b1;
    #(width) sda_pull_out = 1'b0;
  endtask
endmodule

// ===== dv/tb_two_wire_target_bus_frontend.sv
module tb_two_wire_target_bus_frontend;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b_in;
  logic scl;
  logic sda_pull;
  wire logic sda_wire;
  logic sda_out;
  logic sda_oe_out;
  logic rx_valid_out;
  twf_pkg::twf_evt_t rx_evt_out;
  logic tx_valid_in;
  logic [7:0] tx_data_in;
  logic tx_ready_out;
  logic ack_en_in;
  logic standby_out;
  int err_count;
  int comparisons;
  twf_pkg::twf_evt_t evq[$];

  always #10 clk_in = ~clk_in;
  initial begin
    #3.3;
    forever #15 link_clk = ~link_clk;
  end

  // open-drain wire with pull-up
  assign sda_wire = (sda_oe_out ? sda_out : 1'b1) & ~sda_pull;

  twf_two_wire_target_bus_frontend #(.FILT_CYC(3)) twf_two_wire_target_bus_frontend_i (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .link_clk_in(link_clk),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .rx_valid_out(rx_valid_out),
    .rx_evt_out(rx_evt_out),
    .tx_valid_in(tx_valid_in),
    .tx_data_in(tx_data_in),
    .tx_ready_out(tx_ready_out),
    .ack_en_in(ack_en_in),
    .standby_out(standby_out)
  );

  twf_bus_master_model twf_bus_master_model_i (
    .scl_out(scl),
    .sda_pull_out(sda_pull),
    .sda_in(sda_wire)
  );

  always @(posedge clk_in) begin
    if (rx_valid_out === 1'b1) begin
      evq.push_back(rx_evt_out);
    end
  end

  ////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic expect_evt(input twf_pkg::twf_kind_t k, input logic [7:0] d);
    twf_pkg::twf_evt_t e;
    int n;
    n = 0;
    e = '1;
    while (evq.size() == 0 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (evq.size() > 0) begin
      e = evq.pop_front();
    end
    check(e, {k, d}, "event");
  endtask

  task automatic load_tx(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    tx_valid_in <= 1'b1;
    tx_data_in <= d;
    // ready is judged where it is settled; the next rising edge takes the word
    @(negedge clk_in);
    while (tx_ready_out !== 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 100) begin
      err_count++;
    end
    @(posedge clk_in);
    tx_valid_in <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_idle();
    logic r;
    check(standby_out, 1'b1, "standby after reset");
    check(sda_oe_out, 1'b0, "sda released after reset");
    check(tx_ready_out, 1'b1, "tx ready after reset");
    twf_bus_master_model_i.glitch(40);
    repeat (3) twf_bus_master_model_i.clk_bit(1'b1, r);
    repeat (20) @(posedge clk_in);
    check(10'(evq.size()), 10'h0, "no event without start");
    check(standby_out, 1'b1, "still standby");
    check(r, 1'b1, "sda left released");
    check(sda_out, 1'b0, "pull level low");
    $display("test idle done");
  endtask

  task automatic t_write();
    logic ack;
    @(posedge clk_in) ack_en_in <= 1'b1;
    twf_bus_master_model_i.start_cond();
    expect_evt(twf_pkg::EV_START, 8'h00);
    check(standby_out, 1'b0, "awake after start");
    twf_bus_master_model_i.wr_byte(8'ha5, ack);
    check(ack, 1'b0, "ack driven");
    expect_evt(twf_pkg::EV_BYTE, 8'ha5);
    @(posedge clk_in) ack_en_in <= 1'b0;
    twf_bus_master_model_i.wr_byte(8'h3c, ack);
    check(ack, 1'b1, "no ack when disabled");
    expect_evt(twf_pkg::EV_BYTE, 8'h3c);
    twf_bus_master_model_i.stop_cond();
    expect_evt(twf_pkg::EV_STOP, 8'h00);
    repeat (10) @(posedge clk_in);
    check(standby_out, 1'b1, "standby after stop");
    $display("test write done");
  endtask

  task automatic t_restart();
    logic r;
    logic ack;
    @(posedge clk_in) ack_en_in <= 1'b1;
    twf_bus_master_model_i.start_cond();
    expect_evt(twf_pkg::EV_START, 8'h00);
    twf_bus_master_model_i.clk_bit(1'b1, r);
    twf_bus_master_model_i.clk_bit(1'b0, r);
    twf_bus_master_model_i.clk_bit(1'b1, r);
    twf_bus_master_model_i.clk_bit(1'b1, r);
    twf_bus_master_model_i.start_cond();
    expect_evt(twf_pkg::EV_START, 8'h00);
    twf_bus_master_model_i.wr_byte(8'h81, ack);
    check(ack, 1'b0, "ack after restart");
    expect_evt(twf_pkg::EV_BYTE, 8'h81);
    twf_bus_master_model_i.stop_cond();
    expect_evt(twf_pkg::EV_STOP, 8'h00);
    $display("test restart done");
  endtask

  task automatic t_read();
    logic ack;
    logic [7:0] d;
    @(posedge clk_in) ack_en_in <= 1'b1;
    load_tx(8'h96);
    twf_bus_master_model_i.start_cond();
    expect_evt(twf_pkg::EV_START, 8'h00);
    twf_bus_master_model_i.wr_byte(8'h55, ack);
    check(ack, 1'b0, "ack before read");
    expect_evt(twf_pkg::EV_BYTE, 8'h55);
    twf_bus_master_model_i.rd_byte(1'b1, d);
    check(d, 8'h96, "byte sent");
    expect_evt(twf_pkg::EV_NACK, 8'h00);
    repeat (30) @(posedge clk_in);
    check(sda_oe_out, 1'b0, "released after nack");
    twf_bus_master_model_i.stop_cond();
    expect_evt(twf_pkg::EV_STOP, 8'h00);
    $display("test read done");
  endtask

  ////////////////////////////////////////////////////////////
  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    rst_b_in = 1'b0;
    tx_valid_in = 1'b0;
    tx_data_in = 8'h00;
    ack_en_in = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    twf_bus_master_model_i.power_up();
    t_idle();
    t_write();
    t_restart();
    t_read();
    results();
  end

  initial begin
    #1000000;
    err_count++;
    results();
  end
endmodule
